// [common/frc_pkg.sv]
package frc_pkg;

    // ------------------------------------------------------------
    // Serial command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_SET_PARAMS_NV = 8'h65;
    localparam logic [7:0] OP_SET_PARAMS_VOL = 8'hc0;
    localparam logic [7:0] OP_SET_PARAMS_VOL_WE = 8'h63;
    localparam logic [7:0] OP_WRITE_FUNCTION = 8'h42;

    // ------------------------------------------------------------
    // Function register layout
    // ------------------------------------------------------------
    localparam int FN_RESET_DISABLE = 0;
    localparam int FN_BOTTOM = 1;
    localparam int FN_PROGRAM_SUSPENDED_FLAG = 2;
    localparam int FN_ERASE_SUSPENDED_FLAG = 3;
    localparam int FN_LOCK_LO = 4;
    localparam int FN_LOCK_HI = 7;
    localparam logic [7:0] FN_OTP_MASK = 8'hf3;
    localparam logic [7:0] FN_RESET_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Read parameter register layout
    // ------------------------------------------------------------
    localparam int RP_PIN_ROLE = 7;
    localparam int RP_DUMMY_HI = 6;
    localparam int RP_DUMMY_LO = 3;
    localparam int RP_WRAP = 2;
    localparam int RP_BURST_HI = 1;
    localparam int RP_BURST_LO = 0;
    localparam logic [7:0] RP_RESET_VALUE = 8'h00;
    localparam logic [6:0] BURST_MIN_BYTES = 7'h08;

    // ------------------------------------------------------------
    // Link framing
    // ------------------------------------------------------------
    localparam logic [4:0] LINK_OPCODE_BITS = 5'h08;
    localparam logic [4:0] LINK_FRAME_BITS = 5'h10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic {FRC_ST_LOAD, FRC_ST_RUN} frc_state_t;

    typedef struct packed {
        logic full;
        logic [7:0] opcode;
        logic [7:0] data;
    } frc_frame_t;

    typedef struct packed {
        logic [14:0] shift;
        frc_frame_t frame;
        logic toggle;
    } frc_link_t;

    typedef struct packed {
        logic hold;
        logic shared_reset;
        logic data_line_3;
        logic wp_active;
        logic dedicated_reset;
    } frc_pins_t;

    typedef struct packed {
        frc_state_t state;
        logic [2:0] sync;
        logic seen;
        logic write_enable;
        logic [7:0] fn;
        logic [7:0] rp_nv;
        logic [7:0] rp_vol;
        frc_pins_t pins;
        logic [3:0] dummy;
        logic wrap_en;
        logic [6:0] burst;
    } frc_core_t;

endpackage : frc_pkg

// [design/frc_regs.sv]
`timescale 1ns/1ps
// Summary of operation
// - Bit 0 one-time disables dedicated reset pin.
// - Bit 1 one-time moves protection to bottom.
// - Bit 2 flags suspended program until resume.
// - Bit 3 flags suspended erase until resume.
// - Bits 4-7 one-time lock information rows.
// - Power-up copies stored parameters into live copy.
// - Parameter bit 7 picks hold or reset role.
// - Dedicated-reset package ignores bit 7; function bit 0 picks hold or reset.
// - Parameter bits 6:3 give dummy cycles.
// - Parameter bits 1:0 give burst length.
// - Bit 2 selects burst wrap or array wrap.
// - 65h writes stored copy, C0h/63h live copy.
// - C0h needs no prior write enable.
// - Quad enable turns control pins into data.
module frc_regs
    import frc_pkg::*;
#(
    parameter int DEDICATED_RESET_PKG = 1,
    parameter logic [7:0] RP_NV_INIT = RP_RESET_VALUE
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_quad_enable_bit,
    input wire logic i_quad_command_mode,
    input wire logic i_program_busy,
    input wire logic i_erase_busy,
    input wire logic i_suspend_cmd,
    input wire logic i_resume_cmd,
    output logic [7:0] o_function_reg,
    output logic [7:0] o_read_params_nv,
    output logic [7:0] o_read_params_vol,
    output logic o_write_enable,
    output logic o_shared_pin_hold,
    output logic o_shared_pin_reset,
    output logic o_data_line_3,
    output logic o_write_protect_active,
    output logic o_dedicated_reset_active,
    output logic o_protect_area_bottom_select,
    output logic [3:0] o_info_row_lock,
    output logic o_program_suspended_flag,
    output logic o_erase_suspended_flag,
    output logic [3:0] o_dummy_cycles,
    output logic o_wrap_enable,
    output logic [6:0] o_burst_bytes
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    generate
        if (DEDICATED_RESET_PKG < 0 || DEDICATED_RESET_PKG > 1) begin : g_bad_pkg
            $error("DEDICATED_RESET_PKG must be 0 or 1");
        end
    endgenerate

    localparam logic PKG_DEDICATED = (DEDICATED_RESET_PKG == 1);
    // Packages without a dedicated reset pin ship with the disable set.
    localparam logic [7:0] FN_INIT = FN_RESET_VALUE | {7'h00, ~PKG_DEDICATED};

    // ------------------------------------------------------------
    // Command decoding
    // ------------------------------------------------------------
    function automatic logic needs_write_enable(input logic [7:0] op);
        needs_write_enable = (op == OP_SET_PARAMS_NV) ||
                             (op == OP_SET_PARAMS_VOL_WE) ||
                             (op == OP_WRITE_FUNCTION);
    endfunction : needs_write_enable

    function automatic logic is_data_command(input logic [7:0] op);
        is_data_command = needs_write_enable(op) || (op == OP_SET_PARAMS_VOL);
    endfunction : is_data_command

    // ------------------------------------------------------------
    // Link side, clocked by the serial clock
    // ------------------------------------------------------------
    frc_link_t link_r;
    frc_link_t link_nxt;
    logic [4:0] link_count_r;
    logic [4:0] link_count_nxt;
    logic link_clear_n;

    // The bit count restarts whenever chip select is high, since the
    // serial clock may stand still between frames.
    assign link_clear_n = i_rst_n & ~i_cs_n;

    always_comb begin
        link_count_nxt = link_count_r;
        if (link_count_r != LINK_FRAME_BITS) begin
            link_count_nxt = link_count_r + 5'h01;
        end
    end

    always_ff @(posedge i_sck or negedge link_clear_n) begin
        if (!link_clear_n) begin
            link_count_r <= 5'h00;
        end else begin
            link_count_r <= link_count_nxt;
        end
    end

    always_comb begin
        link_nxt = link_r;
        link_nxt.shift = {link_r.shift[13:0], i_si};
        // Opcode-only frames are handed over after eight bits; data
        // frames hand over a second time after sixteen.
        if (link_count_nxt == LINK_OPCODE_BITS && link_count_r != LINK_OPCODE_BITS) begin
            link_nxt.frame.full = 1'b0;
            link_nxt.frame.opcode = {link_r.shift[6:0], i_si};
            link_nxt.frame.data = 8'h00;
            link_nxt.toggle = ~link_r.toggle;
        end else if (link_count_nxt == LINK_FRAME_BITS && link_count_r != LINK_FRAME_BITS) begin
            link_nxt.frame.full = 1'b1;
            link_nxt.frame.opcode = link_r.shift[14:7];
            link_nxt.frame.data = {link_r.shift[6:0], i_si};
            link_nxt.toggle = ~link_r.toggle;
        end
    end

    always_ff @(posedge i_sck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            link_r <= '0;
        end else begin
            link_r <= link_nxt;
        end
    end

    // ------------------------------------------------------------
    // Core side
    // ------------------------------------------------------------
    frc_core_t core_r;
    frc_core_t core_nxt;
    logic frame_event;
    logic accept_write;
    logic program_suspended_flag_set;
    logic program_suspended_flag_clr;
    logic erase_suspended_flag_set;
    logic erase_suspended_flag_clr;
    logic [7:0] op;
    logic [7:0] wdata;
    logic [7:0] live;

    always_comb begin
        core_nxt = core_r;
        frame_event = 1'b0;
        accept_write = 1'b0;
        op = link_r.frame.opcode;
        wdata = link_r.frame.data;
        // The frame word is held still for many core cycles before the
        // toggle is seen, so it is safe to read once the toggle settles.
        core_nxt.sync = {core_r.sync[1:0], link_r.toggle};
        if (core_r.sync[2] == core_r.sync[1] && core_r.sync[2] != core_r.seen) begin
            frame_event = 1'b1;
            core_nxt.seen = core_r.sync[2];
        end

        program_suspended_flag_set = i_suspend_cmd & i_program_busy;
        program_suspended_flag_clr = i_resume_cmd & core_r.fn[FN_PROGRAM_SUSPENDED_FLAG];
        erase_suspended_flag_set = i_suspend_cmd & i_erase_busy & ~i_program_busy;
        erase_suspended_flag_clr = i_resume_cmd & core_r.fn[FN_ERASE_SUSPENDED_FLAG] & ~core_r.fn[FN_PROGRAM_SUSPENDED_FLAG];

        case (core_r.state)
            FRC_ST_LOAD: begin
                core_nxt.rp_vol = core_r.rp_nv;
                core_nxt.state = FRC_ST_RUN;
            end
            FRC_ST_RUN: begin
                if (frame_event && !link_r.frame.full) begin
                    if (op == OP_WRITE_ENABLE) begin
                        core_nxt.write_enable = 1'b1;
                    end else if (op == OP_WRITE_DISABLE) begin
                        core_nxt.write_enable = 1'b0;
                    end
                end
                if (frame_event && link_r.frame.full && is_data_command(op)) begin
                    accept_write = !needs_write_enable(op) || core_r.write_enable;
                end
                if (accept_write) begin
                    if (op == OP_SET_PARAMS_NV) begin
                        core_nxt.rp_nv = wdata;
                    end else if (op == OP_WRITE_FUNCTION) begin
                        core_nxt.fn = core_r.fn | (wdata & FN_OTP_MASK);
                    end else begin
                        core_nxt.rp_vol = wdata;
                    end
                    if (needs_write_enable(op)) begin
                        core_nxt.write_enable = 1'b0;
                    end
                end
            end
            default: begin
                core_nxt.state = FRC_ST_LOAD;
            end
        endcase

        core_nxt.fn[FN_PROGRAM_SUSPENDED_FLAG] = program_suspended_flag_set | (core_r.fn[FN_PROGRAM_SUSPENDED_FLAG] & ~program_suspended_flag_clr);
        core_nxt.fn[FN_ERASE_SUSPENDED_FLAG] = erase_suspended_flag_set | (core_r.fn[FN_ERASE_SUSPENDED_FLAG] & ~erase_suspended_flag_clr);

        live = core_r.rp_vol;

        core_nxt.pins.data_line_3 = i_quad_enable_bit | i_quad_command_mode;
        core_nxt.pins.wp_active = ~i_quad_enable_bit;
        core_nxt.pins.hold = 1'b0;
        core_nxt.pins.shared_reset = 1'b0;
        core_nxt.pins.dedicated_reset = PKG_DEDICATED & ~core_r.fn[FN_RESET_DISABLE];
        if (!(i_quad_enable_bit | i_quad_command_mode)) begin
            if (PKG_DEDICATED) begin
                core_nxt.pins.shared_reset = core_r.fn[FN_RESET_DISABLE];
                core_nxt.pins.hold = ~core_r.fn[FN_RESET_DISABLE];
            end else begin
                core_nxt.pins.shared_reset = live[RP_PIN_ROLE];
                core_nxt.pins.hold = ~live[RP_PIN_ROLE];
            end
        end

        core_nxt.dummy = live[RP_DUMMY_HI:RP_DUMMY_LO];
        core_nxt.burst = BURST_MIN_BYTES << live[RP_BURST_HI:RP_BURST_LO];
        core_nxt.wrap_en = live[RP_WRAP];
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_r.state <= FRC_ST_LOAD;
            core_r.sync <= 3'h0;
            core_r.seen <= 1'b0;
            core_r.write_enable <= 1'b0;
            core_r.fn <= FN_INIT;
            core_r.rp_nv <= RP_NV_INIT;
            core_r.rp_vol <= RP_RESET_VALUE;
            core_r.pins <= '0;
            core_r.dummy <= 4'h0;
            core_r.wrap_en <= 1'b0;
            core_r.burst <= BURST_MIN_BYTES;
        end else begin
            core_r <= core_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Pin roles and read settings lag the live copy by one cycle; this
    // keeps every output a plain flip-flop.
    assign o_function_reg = core_r.fn;
    assign o_read_params_nv = core_r.rp_nv;
    assign o_read_params_vol = core_r.rp_vol;
    assign o_write_enable = core_r.write_enable;
    assign o_shared_pin_hold = core_r.pins.hold;
    assign o_shared_pin_reset = core_r.pins.shared_reset;
    assign o_data_line_3 = core_r.pins.data_line_3;
    assign o_write_protect_active = core_r.pins.wp_active;
    assign o_dedicated_reset_active = core_r.pins.dedicated_reset;
    assign o_protect_area_bottom_select = core_r.fn[FN_BOTTOM];
    assign o_info_row_lock = core_r.fn[FN_LOCK_HI:FN_LOCK_LO];
    assign o_program_suspended_flag = core_r.fn[FN_PROGRAM_SUSPENDED_FLAG];
    assign o_erase_suspended_flag = core_r.fn[FN_ERASE_SUSPENDED_FLAG];
    assign o_dummy_cycles = core_r.dummy;
    assign o_wrap_enable = core_r.wrap_en;
    assign o_burst_bytes = core_r.burst;

endmodule : frc_regs

// [tb/frc_regs_sva.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register block checker
// ------------------------------------------------------------
module frc_regs_sva
    import frc_pkg::*;
#(
    parameter int DEDICATED_RESET_PKG = 1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_quad_enable_bit,
    input wire logic i_quad_command_mode,
    input wire logic i_program_busy,
    input wire logic i_erase_busy,
    input wire logic i_suspend_cmd,
    input wire logic i_resume_cmd,
    input wire logic [7:0] o_function_reg,
    input wire logic [7:0] o_read_params_nv,
    input wire logic [7:0] o_read_params_vol,
    input wire logic o_shared_pin_hold,
    input wire logic o_shared_pin_reset,
    input wire logic o_data_line_3,
    input wire logic o_write_protect_active,
    input wire logic o_program_suspended_flag,
    input wire logic o_erase_suspended_flag,
    input wire logic [3:0] o_dummy_cycles,
    input wire logic o_wrap_enable,
    input wire logic [6:0] o_burst_bytes
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    logic spi_role;
    logic role_sel;
    logic [7:0] vol_q;
    assign spi_role = !i_quad_enable_bit && !i_quad_command_mode;
    assign role_sel = (DEDICATED_RESET_PKG != 0) ? o_function_reg[0] : o_read_params_vol[7];
    // Derived outputs lag the live copy by one cycle.
    always_ff @(posedge i_clock) vol_q <= o_read_params_vol;
    sequence s_leave_reset; $rose(i_rst_n); endsequence
    sequence s_spi_role; spi_role; endsequence
    AST_LOAD_LIVE: assert property (s_leave_reset |=> o_read_params_vol == o_read_params_nv)
        else $error("live copy not loaded");
    AST_DUMMY_WRAP: assert property ({o_dummy_cycles, o_wrap_enable} == vol_q[6:2])
        else $error("dummy or wrap wrong");
    AST_BURST: assert property (o_burst_bytes == (BURST_MIN_BYTES << vol_q[1:0]))
        else $error("burst length wrong");
    AST_QUAD_PINS: assert property (!spi_role |=> o_data_line_3 && !o_shared_pin_hold && !o_shared_pin_reset)
        else $error("quad pin role wrong");
    AST_WP_PIN: assert property (1 |=> o_write_protect_active == !$past(i_quad_enable_bit))
        else $error("write protect role wrong");
    AST_SHARED_ROLE: assert property (s_spi_role |=> {o_shared_pin_reset, o_shared_pin_hold} == {$past(role_sel), !$past(role_sel)})
        else $error("shared pin role wrong");
    AST_OTP_STICKY: assert property ((($past(o_function_reg) & ~o_function_reg) & FN_OTP_MASK) == 8'h00)
        else $error("one-time bit cleared");
    AST_PROGRAM_SUSPENDED_FLAG_SET: assert property (i_suspend_cmd && i_program_busy |=> o_program_suspended_flag)
        else $error("program suspend not flagged");
    AST_PROGRAM_SUSPENDED_FLAG_CLR: assert property (i_resume_cmd && !i_suspend_cmd && o_program_suspended_flag |=> !o_program_suspended_flag)
        else $error("program suspend not cleared");
    AST_ERASE_SUSPENDED_FLAG_SET: assert property (i_suspend_cmd && !i_program_busy && i_erase_busy |=> o_erase_suspended_flag)
        else $error("erase suspend not flagged");
    AST_ERASE_SUSPENDED_FLAG_CLR: assert property (i_resume_cmd && !i_suspend_cmd && !o_program_suspended_flag && o_erase_suspended_flag |=> !o_erase_suspended_flag)
        else $error("erase suspend not cleared");
endmodule : frc_regs_sva

// [tb/frc_host.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host model
// ------------------------------------------------------------
module frc_host (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    int half = 15;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    task automatic frame(input logic [15:0] w, input int nb);
        for (int i = 0; i < nb; i++) begin
            o_cs_n = 1'b0;
            o_si = w[15 - i];
            #(half) o_sck = 1'b1;
            #(half) o_sck = 1'b0;
        end
        #(half) o_cs_n = 1'b1;
        // A released line must not keep showing the last bit.
        o_si = ~o_si;
        #300;
    endtask : frame
endmodule : frc_host

// [tb/tb.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Testbench top
// ------------------------------------------------------------
module tb;
    import frc_pkg::*;
    localparam logic [7:0] NV0 = 8'h9a;
    logic i_clock = 1'b0;
    logic i_rst_n = 1'b0;
    logic qe = 1'b0, qm = 1'b0, pb = 1'b0, eb = 1'b0, sus = 1'b0, res = 1'b0;
    logic sck, cs_n, si, we;
    logic [7:0] fn, nv, vol, m_fn, m_nv, m_vol;
    logic [6:0] burst;
    logic m_we;
    logic bsel, dres;
    logic [3:0] rows;
    logic [7:0] fn_b;
    logic [31:0] note_v;
    int errors = 0, cmp_count = 0;
    int unsigned seed;
    logic [31:0] q[$];
    event chk_ev;
    always #12.5 i_clock = ~i_clock;
    frc_host host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    frc_regs #(.DEDICATED_RESET_PKG(1), .RP_NV_INIT(NV0)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_quad_enable_bit(qe), .i_quad_command_mode(qm),
        .i_program_busy(pb), .i_erase_busy(eb), .i_suspend_cmd(sus), .i_resume_cmd(res),
        .o_function_reg(fn), .o_read_params_nv(nv), .o_read_params_vol(vol), .o_write_enable(we),
        .o_shared_pin_hold(), .o_shared_pin_reset(), .o_data_line_3(), .o_write_protect_active(),
        .o_dedicated_reset_active(dres), .o_protect_area_bottom_select(bsel), .o_info_row_lock(rows),
        .o_program_suspended_flag(), .o_erase_suspended_flag(), .o_dummy_cycles(), .o_wrap_enable(),
        .o_burst_bytes(burst));
    // A package without the dedicated pin, so the parameter bit picks the shared pin role.
    frc_regs #(.DEDICATED_RESET_PKG(0), .RP_NV_INIT(NV0)) DUT_B (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_quad_enable_bit(qe), .i_quad_command_mode(qm),
        .i_program_busy(pb), .i_erase_busy(eb), .i_suspend_cmd(sus), .i_resume_cmd(res),
        .o_function_reg(fn_b), .o_read_params_nv(), .o_read_params_vol(), .o_write_enable(),
        .o_shared_pin_hold(), .o_shared_pin_reset(), .o_data_line_3(), .o_write_protect_active(),
        .o_dedicated_reset_active(), .o_protect_area_bottom_select(), .o_info_row_lock(),
        .o_program_suspended_flag(), .o_erase_suspended_flag(), .o_dummy_cycles(), .o_wrap_enable(),
        .o_burst_bytes());
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic note();
        q.push_back({m_fn, m_nv, m_vol, m_we, BURST_MIN_BYTES << m_vol[1:0]});
        repeat (12) @(posedge i_clock);
        #2;
        -> chk_ev;
    endtask : note
    always @(chk_ev) begin
        note_v = q.pop_front();
        check({fn, nv, vol, we, burst}, note_v);
        check({bsel, rows, dres}, {note_v[25], note_v[31:28], ~note_v[24]});
        check(fn_b, note_v[31:24] | 8'h01);
    end
    task automatic do_reset();
        i_rst_n = 1'b0;
        repeat (16) @(posedge i_clock);
        #2 i_rst_n = 1'b1;
        {m_fn, m_nv, m_vol, m_we} = {FN_RESET_VALUE, NV0, NV0, 1'b0};
        note();
    endtask : do_reset
    task automatic send(input logic [7:0] op, input logic [7:0] d, input int nb);
        host.frame({op, d}, nb);
        if (nb == 8 && op == OP_WRITE_ENABLE) m_we = 1'b1;
        if (nb == 8 && op == OP_WRITE_DISABLE) m_we = 1'b0;
        if (nb == 16 && op == OP_SET_PARAMS_VOL) m_vol = d;
        if (nb == 16 && m_we && op == OP_SET_PARAMS_NV) {m_nv, m_we} = {d, 1'b0};
        if (nb == 16 && m_we && op == OP_SET_PARAMS_VOL_WE) {m_vol, m_we} = {d, 1'b0};
        if (nb == 16 && m_we && op == OP_WRITE_FUNCTION) {m_fn, m_we} = {m_fn | (d & FN_OTP_MASK), 1'b0};
        note();
    endtask : send
    task automatic pulse(input logic p, input logic e, input logic s, input logic r, input int idx, input logic v);
        @(posedge i_clock);
        #2 {pb, eb, sus, res} = {p, e, s, r};
        @(posedge i_clock);
        #2 {sus, res} = 2'b00;
        m_fn[idx] = v;
        note();
    endtask : pulse
    task automatic quad_mix();
        repeat (40) begin
            @(posedge i_clock);
            #2 {qe, qm} = 2'($urandom);
        end
        @(posedge i_clock);
        #2 {qe, qm} = 2'b00;
    endtask : quad_mix
    task automatic close_out();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial begin
        #400000;
        errors++;
        close_out();
    end
    initial begin
        seed = $urandom(32'h6969);
        do_reset();
        quad_mix();
        $display("test reset done");
        repeat (4) send(OP_SET_PARAMS_VOL, 8'($urandom), 16);
        send(OP_SET_PARAMS_NV, 8'h5b, 16);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(OP_SET_PARAMS_NV, 8'h3c, 16);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(OP_SET_PARAMS_VOL_WE, 8'($urandom), 16);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(OP_WRITE_DISABLE, 8'h00, 8);
        send(OP_SET_PARAMS_VOL_WE, 8'hff, 16);
        $display("test parameters done");
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(OP_WRITE_FUNCTION, 8'h0e, 16);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(OP_WRITE_FUNCTION, 8'hf1, 16);
        send(OP_WRITE_ENABLE, 8'h00, 8);
        send(OP_WRITE_FUNCTION, 8'h00, 16);
        quad_mix();
        $display("test function done");
        pulse(1'b1, 1'b0, 1'b1, 1'b0, FN_PROGRAM_SUSPENDED_FLAG, 1'b1);
        pulse(1'b1, 1'b0, 1'b0, 1'b1, FN_PROGRAM_SUSPENDED_FLAG, 1'b0);
        pulse(1'b0, 1'b1, 1'b1, 1'b0, FN_ERASE_SUSPENDED_FLAG, 1'b1);
        pulse(1'b0, 1'b1, 1'b1, 1'b1, FN_ERASE_SUSPENDED_FLAG, 1'b1);
        pulse(1'b0, 1'b0, 1'b0, 1'b1, FN_ERASE_SUSPENDED_FLAG, 1'b0);
        $display("test suspend done");
        do_reset();
        $display("test second reset done");
        #1;
        close_out();
    end
endmodule : tb
bind frc_regs frc_regs_sva #(.DEDICATED_RESET_PKG(DEDICATED_RESET_PKG)) u_sva (.i_clock, .i_rst_n,
    .i_quad_enable_bit, .i_quad_command_mode, .i_program_busy, .i_erase_busy, .i_suspend_cmd,
    .i_resume_cmd, .o_function_reg, .o_read_params_nv, .o_read_params_vol, .o_shared_pin_hold,
    .o_shared_pin_reset, .o_data_line_3, .o_write_protect_active, .o_program_suspended_flag,
    .o_erase_suspended_flag, .o_dummy_cycles, .o_wrap_enable, .o_burst_bytes);
